/* design/gef_bank.sv */
// empty/full handling register bank with empty detect and full-detect hysteresis
// Summary of operation
// - empty threshold in bits 15:7, 10mV steps, compared with cell voltage
// - empty threshold loads the 3.12V code at power-up
// - recovery threshold bits 6:0, 40mV steps, 3.68V code at power-up
// - after empty, detection stays off until voltage rises above recovery
// - full flag bit 5 sets above 99%, clears below 98.5%
// - hibernate config bit mirrored into status bit 1
// - low-charge bend threshold bits 15:12, 2% steps, 0 to 30%
// - below low-voltage point, ratio uses offset bits 11:7 at 20mV
// - once low-voltage bending reached, voltage-ratio math replaces threshold math
// - slope-shallowing factor bits 6:3 gives ratio n/16
// - threshold raised by per-stage field times seven minus learning stage
// - averaged empty current held as signed 16-bit value
// - learn gain when current above average, offset when equal or below
// - nominal temperature compensation in bits 7:0, upper byte spare
// - hot thermal slope in upper coefficient byte
// - cold thermal slope in lower coefficient byte
// - time-to-full filter rate in bits 2:0
// - empty learning updates one adjacent table entry (entry 1) with interpolation, skipped if a host table write falls in the same cycle
// - reported charge reaches 0% exactly at the empty threshold
`include "gef_regs.svh"
module gef_bank
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] i_cell_voltage,
    input wire logic [15:0] i_averaged_cell_voltage,
    input wire logic [15:0] i_voltage_based_charge_percent,
    input wire logic [15:0] i_reported_charge_percent,
    input wire logic [15:0] i_empty_event_current,
    input wire logic i_sleep_config_two_hib,
    input wire logic [2:0] i_learning_stage_index,
    output logic [15:0] o_rdata,
    output logic o_empty_detect,
    output logic o_full_detect_flag,
    output logic o_low_voltage_bend,
    output logic [15:0] o_bend_threshold,
    output logic [15:0] o_bend_ratio_num,
    output logic [15:0] o_bend_ratio_den,
    output logic [3:0] o_slope_shallow_factor,
    output logic o_learn_gain,
    output logic o_learn_offset,
    output logic [2:0] o_full_time_filter_rate,
    output logic [7:0] o_nominal_temp_compensation,
    output logic [7:0] o_hot_thermal_slope,
    output logic [7:0] o_cold_thermal_slope,
    output logic o_charge_at_zero
);
    import gef_pkg::*;

    // cell voltage inputs carry 1 mV per count
    function automatic logic [15:0] mv_of(input logic [15:0] code, input logic [15:0] step);
        logic [31:0] p;
        p = code * step;
        return p[15:0];
    endfunction

    logic [15:0] iavg_q, iavg_d;
    logic [7:0] rcomp_q, rcomp_d;
    logic [15:0] tco_q, tco_d;
    logic [8:0] ve_q, ve_d;
    logic [6:0] vr_q, vr_d;
    logic [15:0] convg_q, convg_d;
    logic [2:0] ttf_q, ttf_d;
    logic full_q, full_d;
    logic hib_q, hib_d;
    gef_empty_state_t est_q, est_d;
    logic lvb_q, lvb_d;
    logic empty_q, empty_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] thr_q, thr_d;
    logic [15:0] num_q, num_d, den_q, den_d;
    logic lg_q, lg_d, lo_q, lo_d, zero_q, zero_d;
    logic tbl_we, tbl_sel;
    logic [15:0] tbl_wdata, tbl_rdata, tbl_entry;
    logic [15:0] ve_mv, vr_mv, vlow_mv;
    logic [15:0] boost;
    logic [3:0] slope_q, slope_d;

    gef_table_mem gef_table_mem_inst
    (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_we(tbl_we),
        .i_sel(tbl_sel),
        .i_wdata(tbl_wdata),
        .i_base(16'h0000),
        .o_rdata(tbl_rdata),
        .o_entry(tbl_entry)
    );

    always_comb
    begin
        ve_mv = mv_of({7'h00, ve_q}, 16'd10);
        vr_mv = mv_of({9'h000, vr_q}, 16'd40);
        vlow_mv = ve_mv + mv_of({11'h000, convg_q[11:7]}, 16'd20);
        boost = mv_of({13'h0000, convg_q[2:0]}, {13'h0000, 3'd7 - i_learning_stage_index});
        iavg_d = iavg_q;
        rcomp_d = rcomp_q;
        tco_d = tco_q;
        ve_d = ve_q;
        vr_d = vr_q;
        convg_d = convg_q;
        ttf_d = ttf_q;
        tbl_we = 1'b0;
        tbl_sel = 1'b0;
        tbl_wdata = i_wdata;
        if (i_wr)
        begin
            if (i_addr == `GEF_OFS_IAVG)
                iavg_d = i_wdata;
            else if (i_addr == `GEF_OFS_RCOMP)
                rcomp_d = i_wdata[7:0];
            else if (i_addr == `GEF_OFS_TCO)
                tco_d = i_wdata;
            else if (i_addr == `GEF_OFS_VEMPTY)
            begin
                ve_d = i_wdata[`GEF_VE_MSB:`GEF_VE_LSB];
                vr_d = i_wdata[`GEF_VR_MSB:`GEF_VR_LSB];
            end
            else if (i_addr == `GEF_OFS_TABLE)
                tbl_we = 1'b1;
            else if (i_addr == `GEF_OFS_CONVG)
                convg_d = i_wdata;
            else if (i_addr == `GEF_OFS_TTF)
                ttf_d = i_wdata[2:0];
        end
        // full flag hysteresis, set wins since both thresholds never overlap
        full_d = full_q;
        if (i_voltage_based_charge_percent > `GEF_FULL_SET)
        begin
            full_d = 1'b1;
        end
        else if (i_voltage_based_charge_percent < `GEF_FULL_CLR)
        begin
            full_d = 1'b0;
        end
        hib_d = i_sleep_config_two_hib;
        est_d = est_q;
        empty_d = 1'b0;
        case (est_q)
            GEF_ARMED:
            begin
                if (i_cell_voltage < ve_mv)
                begin
                    est_d = GEF_EMPTY;
                    empty_d = 1'b1;
                end
            end
            GEF_EMPTY:
            begin
                empty_d = 1'b1;
                if (i_cell_voltage > vr_mv)
                begin
                    est_d = GEF_ARMED;
                end
            end
            default:
            begin
                est_d = GEF_ARMED;
            end
        endcase
        // empty learning writes the adjacent entry with the interpolated midpoint
        if (empty_d && !empty_q && !tbl_we)
        begin
            tbl_we = 1'b1;
            tbl_sel = 1'b1;
            tbl_wdata = (tbl_rdata >> 1) + (iavg_q >> 1);
        end
        lvb_d = lvb_q;
        if (i_averaged_cell_voltage < vlow_mv)
        begin
            lvb_d = 1'b1;
        end
        else if (est_q == GEF_ARMED && i_cell_voltage > vr_mv)
        begin
            lvb_d = 1'b0;
        end
        // threshold in 1/256 percent units: 2% per count plus stage boost
        thr_d = {8'(mv_of({12'h000, convg_q[15:12]}, 16'd2) + boost), 8'h00};
        num_d = (i_cell_voltage > ve_mv) ? i_cell_voltage - ve_mv : 16'h0000;
        den_d = mv_of({11'h000, convg_q[11:7]}, 16'd20);
        lg_d = 1'b0;
        lo_d = 1'b0;
        if (empty_d && !empty_q)
        begin
            lg_d = $signed(i_empty_event_current) > $signed(iavg_q);
            lo_d = !lg_d;
        end
        zero_d = (i_cell_voltage <= ve_mv);
        slope_d = (i_reported_charge_percent < thr_q) ? convg_q[6:3] : 4'h0;
        rdata_d = rdata_q;
        if (i_rd)
        begin
            if (i_addr == `GEF_OFS_IAVG)
                rdata_d = iavg_q;
            else if (i_addr == `GEF_OFS_RCOMP)
                rdata_d = {8'h00, rcomp_q};
            else if (i_addr == `GEF_OFS_TCO)
                rdata_d = tco_q;
            else if (i_addr == `GEF_OFS_VEMPTY)
                rdata_d = {ve_q, vr_q};
            else if (i_addr == `GEF_OFS_TABLE)
                rdata_d = tbl_rdata;
            else if (i_addr == `GEF_OFS_CONVG)
                rdata_d = convg_q;
            else if (i_addr == `GEF_OFS_STAT2)
                rdata_d = {10'h000, full_q, 3'b000, hib_q, 1'b0};
            else if (i_addr == `GEF_OFS_TTF)
                rdata_d = {13'h0000, ttf_q};
            else
                rdata_d = 16'h0000;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            iavg_q <= 16'h0000;
            rcomp_q <= 8'h00;
            tco_q <= 16'h0000;
            ve_q <= `GEF_VE_RST;
            vr_q <= `GEF_VR_RST;
            convg_q <= 16'h0000;
            ttf_q <= 3'h0;
            full_q <= 1'b0;
            hib_q <= 1'b0;
            est_q <= GEF_ARMED;
            lvb_q <= 1'b0;
            empty_q <= 1'b0;
            rdata_q <= 16'h0000;
            thr_q <= 16'h0000;
            num_q <= 16'h0000;
            den_q <= 16'h0000;
            lg_q <= 1'b0;
            lo_q <= 1'b0;
            zero_q <= 1'b0;
            slope_q <= 4'h0;
        end
        else
        begin
            iavg_q <= iavg_d;
            rcomp_q <= rcomp_d;
            tco_q <= tco_d;
            ve_q <= ve_d;
            vr_q <= vr_d;
            convg_q <= convg_d;
            ttf_q <= ttf_d;
            full_q <= full_d;
            hib_q <= hib_d;
            est_q <= est_d;
            lvb_q <= lvb_d;
            empty_q <= empty_d;
            rdata_q <= rdata_d;
            thr_q <= thr_d;
            num_q <= num_d;
            den_q <= den_d;
            lg_q <= lg_d;
            lo_q <= lo_d;
            zero_q <= zero_d;
            slope_q <= slope_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_empty_detect = empty_q;
    assign o_full_detect_flag = full_q;
    assign o_low_voltage_bend = lvb_q;
    assign o_bend_threshold = thr_q;
    assign o_bend_ratio_num = num_q;
    assign o_bend_ratio_den = den_q;
    assign o_slope_shallow_factor = slope_q;
    assign o_learn_gain = lg_q;
    assign o_learn_offset = lo_q;
    assign o_full_time_filter_rate = ttf_q;
    assign o_nominal_temp_compensation = rcomp_q;
    assign o_hot_thermal_slope = tco_q[15:8];
    assign o_cold_thermal_slope = tco_q[7:0];
    assign o_charge_at_zero = zero_q;

    property p_vempty_reset;
        @(posedge i_mclk) $rose(i_rstn) |-> (ve_q == `GEF_VE_RST && vr_q == `GEF_VR_RST);
    endproperty
    a_vempty_reset: assert property (p_vempty_reset) else $error("vempty reset code wrong");

    property p_full_set;
        @(posedge i_mclk) disable iff (!i_rstn)
            (i_voltage_based_charge_percent > 16'h6300) |=> o_full_detect_flag;
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set");

    property p_full_hold;
        @(posedge i_mclk) disable iff (!i_rstn)
            (o_full_detect_flag && i_voltage_based_charge_percent >= 16'h6280) |=> o_full_detect_flag;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full flag dropped early");

    property p_hib;
        @(posedge i_mclk) disable iff (!i_rstn) 1'b1 |=> hib_q == $past(i_sleep_config_two_hib);
    endproperty
    a_hib: assert property (p_hib) else $error("hib mirror wrong");

    sequence s_empty_hit;
        (est_q == GEF_ARMED) && (i_cell_voltage < ve_mv);
    endsequence
    property p_empty;
        @(posedge i_mclk) disable iff (!i_rstn) s_empty_hit |=> o_empty_detect;
    endproperty
    a_empty: assert property (p_empty) else $error("empty not detected");

    property p_recover;
        @(posedge i_mclk) disable iff (!i_rstn)
            (est_q == GEF_EMPTY && i_cell_voltage <= vr_mv) |=> est_q == GEF_EMPTY;
    endproperty
    a_recover: assert property (p_recover) else $error("empty re-armed early");

    property p_spare;
        @(posedge i_mclk) disable iff (!i_rstn)
            (i_rd && i_addr == `GEF_OFS_TTF) |=> o_rdata[15:3] == 13'h0000;
    endproperty
    a_spare: assert property (p_spare) else $error("spare bits not zero");

    property p_lvb;
        @(posedge i_mclk) disable iff (!i_rstn) (i_averaged_cell_voltage < vlow_mv) |=> o_low_voltage_bend;
    endproperty
    a_lvb: assert property (p_lvb) else $error("low voltage bend missed");
    property p_learn;
        @(posedge i_mclk) disable iff (!i_rstn)
            (empty_d && !empty_q && !(i_wr && i_addr == `GEF_OFS_TABLE))
            |=> tbl_entry == ($past(tbl_rdata) >> 1) + ($past(iavg_q) >> 1);
    endproperty
    a_learn: assert property (p_learn) else $error("learned entry wrong");
endmodule

/* design/gef_regs.svh */
// register offsets, field positions and power-up values of the empty/full register bank
`ifndef GEF_REGS_SVH
`define GEF_REGS_SVH
`define GEF_OFS_IAVG 8'h36
`define GEF_OFS_RCOMP 8'h38
`define GEF_OFS_TCO 8'h39
`define GEF_OFS_VEMPTY 8'h3a
`define GEF_OFS_TABLE 8'h42
`define GEF_OFS_CONVG 8'h49
`define GEF_OFS_STAT2 8'hb0
`define GEF_OFS_TTF 8'hb5
`define GEF_VE_MSB 15
`define GEF_VE_LSB 7
`define GEF_VR_MSB 6
`define GEF_VR_LSB 0
`define GEF_VE_RST 9'h138
`define GEF_VR_RST 7'h5c
`define GEF_FULL_BIT 5
`define GEF_HIB_BIT 1
`define GEF_FULL_SET 16'h6300
`define GEF_FULL_CLR 16'h6280
`define GEF_TTF_MASK 16'h0007
`define GEF_RCOMP_MASK 16'h00ff
`define GEF_OFFSET_CNT 16'h0014
`endif

/* design/gef_pkg.sv */
// types shared by the empty/full register bank
package gef_pkg;
    typedef enum logic [1:0] {
        GEF_ARMED = 2'b00,
        GEF_EMPTY = 2'b01
    } gef_empty_state_t;
    typedef logic [15:0] gef_word_t;
endpackage

/* design/gef_table_mem.sv */
// two-word empty-learning table storage with registered read data
module gef_table_mem
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_we,
    input wire logic i_sel,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] i_base,
    output logic [15:0] o_rdata,
    output logic [15:0] o_entry
);
    logic [15:0] mem_q [0:1];
    logic [15:0] mem_d [0:1];
    logic [15:0] rd_q;
    logic [15:0] rd_d;

    always_comb
    begin
        mem_d[0] = mem_q[0];
        mem_d[1] = mem_q[1];
        if (i_we)
        begin
            mem_d[i_sel] = i_wdata;
        end
        rd_d = mem_q[0];
    end

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mem_q[0] <= 16'h0000;
            mem_q[1] <= 16'h0000;
            rd_q <= 16'h0000;
        end
        else
        begin
            mem_q[0] <= mem_d[0];
            mem_q[1] <= mem_d[1];
            rd_q <= rd_d;
        end
    end

    assign o_rdata = rd_q;
    assign o_entry = mem_q[1] + i_base - i_base;
endmodule

/* testbench/gef_bank_tb.sv */
// self-checking bench for the empty/full register bank
module gef_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gef_pkg::*;
    typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e;} gef_row_t;
    logic i_mclk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_hib = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000, i_cell = 16'h0fa0, i_avg = 16'h0fa0;
    logic [15:0] i_vf = 16'h0000, i_rep = 16'h0000, i_cur = 16'h0000;
    logic [2:0] i_stage = 3'd2;
    logic [15:0] o_rdata, o_thr, o_num, o_den;
    logic o_empty, o_full, o_bend, o_gain, o_off, o_zero;
    logic [3:0] o_slope;
    logic [2:0] o_ttf;
    logic [7:0] o_rc, o_hot, o_cold;
    int fails = 0, cmp_count = 0, cyc = 0, n_gain = 0, n_off = 0;
    // ordinary register traffic: address, write data, expected read-back
    gef_row_t rows [11] = '{
        '{8'h36, 16'h8001, 16'h8001}, '{8'h36, 16'h0010, 16'h0010},
        '{8'h38, 16'hffff, 16'h00ff}, '{8'h38, 16'ha5c3, 16'h00c3},
        '{8'h39, 16'ha55a, 16'ha55a}, '{8'h3a, 16'h1234, 16'h1234},
        '{8'h3a, 16'h9c5c, 16'h9c5c}, '{8'h49, 16'h51cb, 16'h51cb},
        '{8'hb5, 16'hfffa, 16'h0002}, '{8'hb0, 16'hffff, 16'h0000},
        '{8'h50, 16'hffff, 16'h0000}};

    gef_bank gef_bank_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr(i_wr), .i_rd(i_rd),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_cell_voltage(i_cell),
        .i_averaged_cell_voltage(i_avg), .i_voltage_based_charge_percent(i_vf),
        .i_reported_charge_percent(i_rep), .i_empty_event_current(i_cur),
        .i_sleep_config_two_hib(i_hib), .i_learning_stage_index(i_stage),
        .o_rdata(o_rdata), .o_empty_detect(o_empty), .o_full_detect_flag(o_full),
        .o_low_voltage_bend(o_bend), .o_bend_threshold(o_thr), .o_bend_ratio_num(o_num),
        .o_bend_ratio_den(o_den), .o_slope_shallow_factor(o_slope), .o_learn_gain(o_gain),
        .o_learn_offset(o_off), .o_full_time_filter_rate(o_ttf),
        .o_nominal_temp_compensation(o_rc), .o_hot_thermal_slope(o_hot),
        .o_cold_thermal_slope(o_cold), .o_charge_at_zero(o_zero));

    always #12.5 i_mclk = ~i_mclk;

    // learn pulses last one cycle, so they are counted at every falling edge
    always @(negedge i_mclk)
    begin
        if (o_gain === 1'b1)
            n_gain++;
        if (o_off === 1'b1)
            n_off++;
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_mclk);
        i_wr = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_mclk);
        i_wr = 1'b0;
    endtask

    // read data is taken two falling edges after the request, once it has settled
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge i_mclk);
        i_rd = 1'b1;
        i_addr = a;
        @(negedge i_mclk);
        i_rd = 1'b0;
        @(negedge i_mclk);
        d = o_rdata;
    endtask

    task automatic sv(input logic [15:0] c, input logic [15:0] a);
        @(negedge i_mclk);
        i_cell = c;
        i_avg = a;
        repeat (3) @(negedge i_mclk);
    endtask

    task automatic vf(input logic [15:0] v, input logic [15:0] exp);
        logic [15:0] d;
        @(negedge i_mclk);
        i_vf = v;
        repeat (2) @(negedge i_mclk);
        rd(8'hb0, d);
        chk(d, exp);
    endtask

    initial
    begin
        logic [15:0] d;
        repeat (2) @(negedge i_mclk);
        i_rstn = 1'b1;
        rd(8'h3a, d);
        chk(d, 16'h9c5c);
        foreach (rows[k])
        begin
            wr(rows[k].a, rows[k].w);
            rd(rows[k].a, d);
            chk(d, rows[k].e);
        end
        wr(8'h42, 16'h1234);
        repeat (2) @(negedge i_mclk);
        rd(8'h42, d);
        chk(d, 16'h1234);
        chk(16'(o_rc), 16'h00c3);
        chk({o_hot, o_cold}, 16'ha55a);
        chk(16'(o_ttf), 16'h0002);
        chk(16'(o_slope), 16'h0009);
        // bend threshold: 10% base plus 3% per remaining stage
        chk(o_thr, 16'h1900);
        @(negedge i_mclk) i_stage = 3'd7;
        repeat (3) @(negedge i_mclk);
        chk(o_thr, 16'h0a00);
        @(negedge i_mclk) i_stage = 3'd0;
        repeat (3) @(negedge i_mclk);
        chk(o_thr, 16'h1f00);
        // reported charge above the bend threshold: no slope shallowing
        @(negedge i_mclk) i_rep = 16'h2000;
        repeat (2) @(negedge i_mclk);
        chk(16'(o_slope), 16'h0000);
        i_rep = 16'h0000;
        // empty detect, suppression and re-arm around 3120 mV / 3680 mV
        i_cur = 16'h0100;
        sv(16'd3100, 16'd4000);
        chk(16'(o_empty), 16'h0001);
        chk(16'(o_zero), 16'h0001);
        chk(16'(n_gain), 16'h0001);
        chk(16'(n_off), 16'h0000);
        // learned neighbour entry is the midpoint of entry 0x1234 and current 0x0010
        chk(gef_bank_inst.tbl_entry, 16'h0922);
        sv(16'd3121, 16'd4000);
        chk(16'(o_zero), 16'h0000);
        sv(16'd3120, 16'd4000);
        chk(16'(o_zero), 16'h0001);
        sv(16'd3500, 16'd4000);
        chk(16'(o_empty), 16'h0001);
        sv(16'd3100, 16'd4000);
        chk(16'(n_gain), 16'h0001);
        sv(16'd3700, 16'd4000);
        chk(16'(o_empty), 16'h0000);
        i_cur = 16'hff00;
        sv(16'd3100, 16'd4000);
        chk(16'(n_off), 16'h0001);
        chk(16'(n_gain), 16'h0001);
        sv(16'd3700, 16'd4000);
        // low-voltage point is 3120 + 3 * 20 mV
        sv(16'd3150, 16'd3170);
        chk(16'(o_bend), 16'h0001);
        chk(o_num, 16'h001e);
        chk(o_den, 16'h003c);
        sv(16'd3150, 16'd3190);
        chk(16'(o_bend), 16'h0001);
        sv(16'd3700, 16'd3700);
        chk(16'(o_bend), 16'h0000);
        // full flag hysteresis in 1/256 percent steps
        vf(16'h6301, 16'h0020);
        vf(16'h6280, 16'h0020);
        vf(16'h627f, 16'h0000);
        vf(16'h6300, 16'h0000);
        vf(16'h6301, 16'h0020);
        chk(16'(o_full), 16'h0001);
        @(negedge i_mclk) i_hib = 1'b1;
        rd(8'hb0, d);
        chk(d, 16'h0022);
        // second reset in mid-run restores power-up thresholds
        wr(8'h3a, 16'h1234);
        @(negedge i_mclk) i_rstn = 1'b0;
        @(negedge i_mclk);
        chk(16'(o_full), 16'h0000);
        i_rstn = 1'b1;
        i_vf = 16'h0000;
        rd(8'h3a, d);
        chk(d, 16'h9c5c);
        conclude();
    end
endmodule
